// ===== pwtr_pkg.sv
// Package with offsets, reset values and encodings for the pressure window threshold registers.
package pwtr_pkg;

   // Byte offsets of the four threshold registers on the serial register interface.
   localparam logic [7:0] PWTR_HIGH_LOW_BYTE_ADDR = 8'h46;
   localparam logic [7:0] PWTR_HIGH_HIGH_BYTE_ADDR = 8'h47;
   localparam logic [7:0] PWTR_LOW_LOW_BYTE_ADDR = 8'h48;
   localparam logic [7:0] PWTR_LOW_HIGH_BYTE_ADDR = 8'h49;

   // Number of threshold byte registers and the width of one threshold.
   localparam int PWTR_NUM_BYTES = 4;
   localparam int PWTR_THR_WIDTH = 16;

   // Values after reset and answers for unmapped reads.
   localparam logic [7:0] PWTR_BYTE_RESET = 8'h00;
   localparam logic [7:0] PWTR_UNMAPPED_DATA = 8'h00;
   localparam logic [15:0] PWTR_THR_DISABLED = 16'h0000;

   // Pulse stretch selection that makes the pin follow the condition directly.
   localparam logic [1:0] PWTR_STRETCH_NONE = 2'h0;

   // Window sense encoding: one activates inside the window.
   localparam logic PWTR_SENSE_INSIDE = 1'b1;

endpackage : pwtr_pkg

// ===== pwtr_byte_reg.sv
// One threshold byte register with a stored parity bit for array error detection.
module pwtr_byte_reg
   import pwtr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [7:0] wdata,
   input wire logic flip_lsb,
   output logic [7:0] value,
   output logic parity
);

   typedef struct packed {
      logic [7:0] value;
      logic parity;
   } pwtr_byte_state_type;

   pwtr_byte_state_type state;
   pwtr_byte_state_type next_state;

   // A write stores the byte with fresh parity; a flip disturbs the data only.
   always_comb
   begin
      next_state = state;
      if (wr_en)
      begin
         next_state.value = wdata;
         next_state.parity = ^wdata;
      end
      else if (flip_lsb)
      begin
         next_state.value = state.value ^ 8'h01;
      end
   end

   // Registers the byte state under synchronous reset.
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         state.value <= PWTR_BYTE_RESET;
         state.parity <= 1'b0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign value = state.value;
   assign parity = state.parity;

endmodule : pwtr_byte_reg

// ===== pwtr_window_regs.sv
// Pressure window threshold registers with the window comparator that drives the interrupt pin.
//
// How it works
// - Two 16-bit thresholds, high and low, are kept and form the window for the interrupt pin.
// - Writes to the thresholds are taken only while the init-done lock is clear and ignored once it is set.
// - Every threshold byte carries a parity bit, and any mismatch raises the array error output.
// - Each threshold is an unsigned 16-bit value compared with the scaled pressure sample.
// - A threshold of zero disables only its own comparison while the other keeps working.
// - With both thresholds zero the window condition and the pin stay low.
// - The high threshold low and high bytes sit at 46h and 47h, the low threshold bytes at 48h and 49h.
// - With the sense bit set the condition holds inside the window, otherwise outside it.
// - With no pulse stretch the pin equals the condition from the latest evaluated sample.
module pwtr_window_regs
   import pwtr_pkg::*;
#(
   parameter int THR_WIDTH = PWTR_THR_WIDTH
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic init_done_lock,
   input wire logic fault_inject,
   input wire logic sample_valid,
   input wire logic [THR_WIDTH-1:0] sample_pressure,
   input wire logic window_sense,
   input wire logic [1:0] stretch_select,
   output logic [7:0] reg_rdata,
   output logic write_refused,
   output logic array_error,
   output logic window_cond,
   output logic int_pin
);

   typedef struct packed {
      logic [7:0] rdata;
      logic write_refused;
      logic array_error;
      logic window_cond;
      logic int_pin;
   } pwtr_state_type;

   pwtr_state_type state;
   pwtr_state_type next_state;

   logic [PWTR_NUM_BYTES-1:0] addr_hit;
   logic [PWTR_NUM_BYTES-1:0] byte_wr;
   logic [PWTR_NUM_BYTES-1:0] byte_flip;
   logic [PWTR_NUM_BYTES-1:0] byte_parity;
   logic [7:0] byte_value [PWTR_NUM_BYTES];
   logic [THR_WIDTH-1:0] window_high_threshold;
   logic [THR_WIDTH-1:0] window_low_threshold;
   logic high_enabled;
   logic low_enabled;
   logic above_high;
   logic below_low;
   logic sample_cond;

   // Address decode of the four consecutive threshold bytes.
   assign addr_hit[0] = (reg_addr == PWTR_HIGH_LOW_BYTE_ADDR);
   assign addr_hit[1] = (reg_addr == PWTR_HIGH_HIGH_BYTE_ADDR);
   assign addr_hit[2] = (reg_addr == PWTR_LOW_LOW_BYTE_ADDR);
   assign addr_hit[3] = (reg_addr == PWTR_LOW_HIGH_BYTE_ADDR);

   // Writes pass only while the lock is clear; faults disturb the addressed byte.
   assign byte_wr = (reg_wr_en && !init_done_lock) ? addr_hit : '0;
   assign byte_flip = fault_inject ? addr_hit : '0;

   // Threshold byte storage, one register per byte.
   genvar gi;
   generate
      for (gi = 0; gi < PWTR_NUM_BYTES; gi++)
      begin : g_byte
         pwtr_byte_reg u_byte (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .wr_en(byte_wr[gi]),
            .wdata(reg_wdata),
            .flip_lsb(byte_flip[gi]),
            .value(byte_value[gi]),
            .parity(byte_parity[gi])
         );
      end
   endgenerate

   // Bytes pair into the two unsigned thresholds, low byte first.
   assign window_high_threshold = {byte_value[1], byte_value[0]};
   assign window_low_threshold = {byte_value[3], byte_value[2]};

   // A zero threshold drops out of the comparison.
   assign high_enabled = (window_high_threshold != PWTR_THR_DISABLED);
   assign low_enabled = (window_low_threshold != PWTR_THR_DISABLED);
   assign above_high = high_enabled && (sample_pressure > window_high_threshold);
   assign below_low = low_enabled && (sample_pressure < window_low_threshold);

   // Outside means beyond an enabled threshold; inside is the opposite when any is enabled.
   always_comb
   begin
      if (!high_enabled && !low_enabled)
      begin
         sample_cond = 1'b0;
      end
      else if (window_sense == PWTR_SENSE_INSIDE)
      begin
         sample_cond = !(above_high || below_low);
      end
      else
      begin
         sample_cond = above_high || below_low;
      end
   end

   // Next value of read data, status flags, condition and pin.
   always_comb
   begin
      next_state = state;
      next_state.write_refused = reg_wr_en && init_done_lock && (|addr_hit);
      next_state.array_error = 1'b0;
      for (int i = 0; i < PWTR_NUM_BYTES; i++)
      begin
         if ((^byte_value[i]) != byte_parity[i])
         begin
            next_state.array_error = 1'b1;
         end
      end
      if (reg_rd_en)
      begin
         next_state.rdata = PWTR_UNMAPPED_DATA;
         for (int i = 0; i < PWTR_NUM_BYTES; i++)
         begin
            if (addr_hit[i])
            begin
               next_state.rdata = byte_value[i];
            end
         end
      end
      if (!high_enabled && !low_enabled)
      begin
         next_state.window_cond = 1'b0;
      end
      else if (sample_valid)
      begin
         next_state.window_cond = sample_cond;
      end
      next_state.int_pin = next_state.window_cond && (stretch_select == PWTR_STRETCH_NONE);
   end

   // Registers the block state under synchronous reset.
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         state.rdata <= PWTR_BYTE_RESET;
         state.write_refused <= 1'b0;
         state.array_error <= 1'b0;
         state.window_cond <= 1'b0;
         state.int_pin <= 1'b0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign reg_rdata = state.rdata;
   assign write_refused = state.write_refused;
   assign array_error = state.array_error;
   assign window_cond = state.window_cond;
   assign int_pin = state.int_pin;

   // Checks on the register bank and the comparator.
   default clocking pwtr_cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   a_locked_write_ignored: assert property (
      reg_wr_en && init_done_lock && !fault_inject |=> $stable(window_high_threshold) && $stable(window_low_threshold)
   ) else $error("Threshold changed by a write under lock.");

   a_open_write_stores: assert property (
      reg_wr_en && !init_done_lock && addr_hit[3] |=> window_low_threshold[15:8] == $past(reg_wdata)
   ) else $error("Open write to low threshold high byte not stored.");

   // A locked write to any threshold byte raises the refused flag on the next cycle.
   a_refused_flag_pulse: assert property (
      reg_wr_en && init_done_lock && (|addr_hit) |=> write_refused
   ) else $error("Refused write flag missing.");

   // Without a locked write in the cycle before, the refused flag stays low, so it is a single pulse.
   a_refused_flag_quiet: assert property (
      !(reg_wr_en && init_done_lock && (|addr_hit)) |=> !write_refused
   ) else $error("Refused write flag raised without a locked write.");

   a_parity_error_seen: assert property (
      fault_inject && (|addr_hit) && !reg_wr_en ##1 !reg_wr_en |=> array_error
   ) else $error("Corrupted byte not flagged.");

   a_both_zero_quiet: assert property (
      !high_enabled && !low_enabled |=> !window_cond ##1 !int_pin
   ) else $error("Condition raised with both thresholds zero.");

   a_above_high_out: assert property (
      sample_valid && !window_sense && high_enabled && sample_pressure > window_high_threshold |=> window_cond
   ) else $error("Sample above high threshold not flagged.");

   a_inside_window_cond: assert property (
      sample_valid && window_sense && high_enabled && low_enabled && sample_pressure >= window_low_threshold
      && sample_pressure <= window_high_threshold |=> window_cond
   ) else $error("Sample inside window not flagged.");

   a_low_disabled_ignored: assert property (
      sample_valid && !window_sense && !low_enabled && high_enabled && sample_pressure <= window_high_threshold
      |=> !window_cond
   ) else $error("Disabled low threshold still compared.");

   a_pin_follows_cond: assert property (
      stretch_select == PWTR_STRETCH_NONE |=> int_pin == window_cond
   ) else $error("Pin differs from condition without stretch.");

   a_unmapped_read_zero: assert property (
      reg_rd_en && !(|addr_hit) |=> reg_rdata == PWTR_UNMAPPED_DATA
   ) else $error("Unmapped read returned data.");

   c_locked_write: cover property (reg_wr_en && init_done_lock && (|addr_hit) ##1 write_refused);
   c_inside_hit: cover property (sample_valid && window_sense ##1 window_cond ##1 int_pin);
   c_error_seen: cover property (fault_inject ##2 array_error);
   c_outside_hit: cover property (sample_valid && !window_sense && below_low ##1 window_cond);

endmodule : pwtr_window_regs

// ===== pwtr_host_model.sv
// Host controller model that reaches the threshold registers over the byte register bus.
module pwtr_host_model
   import pwtr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic [7:0] reg_rdata,
   output logic reg_wr_en,
   output logic reg_rd_en,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata
);
   timeunit 1ns;
   timeprecision 1ps;

   // The bus starts idle with both strobes low.
   initial
   begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end

   // One write held over one edge; released lines show the inverse value.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr_en = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_wr_en = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : wr

   // One read; the data is taken once the read edge has passed.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      #1;
      reg_addr = a;
      reg_rd_en = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_rd_en = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask : rd

endmodule : pwtr_host_model

// ===== tb.sv
// Self-checking testbench for the pressure window threshold registers.
module tb
   import pwtr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, rst_n, lock, fault, sv, sense;
   logic [1:0] stretch;
   logic [15:0] p;
   logic wr_en, rd_en, wrf, aerr, cond, pin;
   logic [7:0] addr, wdata, rdata, d;
   int fail_count = 0;
   int cmp_count = 0;

   pwtr_window_regs u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
      .reg_addr(addr), .reg_wdata(wdata), .init_done_lock(lock), .fault_inject(fault),
      .sample_valid(sv), .sample_pressure(p), .window_sense(sense), .stretch_select(stretch),
      .reg_rdata(rdata), .write_refused(wrf), .array_error(aerr), .window_cond(cond), .int_pin(pin));
   pwtr_host_model u_host (.ref_clk(ref_clk), .reg_rdata(rdata), .reg_wr_en(wr_en),
      .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata));

   // Clock of 10 ns period.
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Compares one value and counts it.
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      cmp_count++;
      if (s !== e)
      begin
         fail_count++;
         $display("Error at %0t: saw %h, expected %h", $time, s, e);
      end
   endtask : chk

   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test

   // Presents one sample and checks the condition and the pin after it.
   task automatic smp(input logic s, input logic [15:0] v, input logic c, input logic i);
      @(posedge ref_clk);
      #1;
      sense = s;
      p = v;
      sv = 1'b1;
      @(posedge ref_clk);
      #1;
      sv = 1'b0;
      p = ~v;
      chk(cond, c);
      chk(pin, i);
   endtask : smp

   // Reset values of every byte and of an unmapped place.
   task automatic t_reset();
      for (int a = 8'h46; a <= 8'h4a; a++)
      begin
         u_host.rd(8'(a), d);
         chk(d, PWTR_BYTE_RESET);
      end
      chk(aerr, 1'b0);
      smp(1'b1, 16'h1000, 1'b0, 1'b0);
   endtask : t_reset

   // Four bytes written back to back, then all but the low threshold low byte read back in place.
   task automatic t_regs();
      u_host.wr(PWTR_HIGH_LOW_BYTE_ADDR, 8'h34);
      chk(wrf, 1'b0);
      u_host.wr(PWTR_HIGH_HIGH_BYTE_ADDR, 8'h12);
      u_host.wr(PWTR_LOW_LOW_BYTE_ADDR, 8'h34);
      u_host.wr(PWTR_LOW_HIGH_BYTE_ADDR, 8'h08);
      u_host.rd(PWTR_HIGH_LOW_BYTE_ADDR, d);
      chk(d, 8'h34);
      u_host.rd(PWTR_HIGH_HIGH_BYTE_ADDR, d);
      chk(d, 8'h12);
      u_host.rd(PWTR_LOW_HIGH_BYTE_ADDR, d);
      chk(d, 8'h08);
   endtask : t_regs

   // Window 0834h..1234h at both boundaries, both senses, and the pin held low under a nonzero stretch select.
   task automatic t_window();
      smp(1'b0, 16'h1235, 1'b1, 1'b1);
      smp(1'b0, 16'h1234, 1'b0, 1'b0);
      smp(1'b0, 16'h0833, 1'b1, 1'b1);
      smp(1'b0, 16'h0834, 1'b0, 1'b0);
      smp(1'b0, 16'h8000, 1'b1, 1'b1);
      smp(1'b1, 16'h1000, 1'b1, 1'b1);
      smp(1'b1, 16'hffff, 1'b0, 1'b0);
      stretch = 2'h1;
      smp(1'b0, 16'hffff, 1'b1, 1'b0);
      stretch = PWTR_STRETCH_NONE;
   endtask : t_window

   // A flipped bit raises the array error until the byte is rewritten.
   task automatic t_fault();
      fault = 1'b1;
      u_host.rd(PWTR_HIGH_LOW_BYTE_ADDR, d);
      fault = 1'b0;
      u_host.rd(PWTR_HIGH_LOW_BYTE_ADDR, d);
      chk(d, 8'h35);
      chk(aerr, 1'b1);
      u_host.wr(PWTR_HIGH_LOW_BYTE_ADDR, 8'h34);
      u_host.rd(PWTR_HIGH_LOW_BYTE_ADDR, d);
      chk(aerr, 1'b0);
   endtask : t_fault

   // Either zero threshold leaves the other one working; both zero silence it.
   task automatic t_disable();
      u_host.wr(PWTR_HIGH_LOW_BYTE_ADDR, 8'h00);
      u_host.wr(PWTR_HIGH_HIGH_BYTE_ADDR, 8'h00);
      smp(1'b0, 16'hffff, 1'b0, 1'b0);
      smp(1'b0, 16'h0001, 1'b1, 1'b1);
      u_host.wr(PWTR_HIGH_LOW_BYTE_ADDR, 8'h34);
      u_host.wr(PWTR_HIGH_HIGH_BYTE_ADDR, 8'h12);
      u_host.wr(PWTR_LOW_LOW_BYTE_ADDR, 8'h00);
      u_host.wr(PWTR_LOW_HIGH_BYTE_ADDR, 8'h00);
      smp(1'b0, 16'h0001, 1'b0, 1'b0);
      smp(1'b0, 16'hffff, 1'b1, 1'b1);
      u_host.wr(PWTR_HIGH_LOW_BYTE_ADDR, 8'h00);
      u_host.wr(PWTR_HIGH_HIGH_BYTE_ADDR, 8'h00);
      smp(1'b0, 16'h0001, 1'b0, 1'b0);
      smp(1'b1, 16'h1000, 1'b0, 1'b0);
   endtask : t_disable

   // Writes after the lock are refused and leave the byte as it was.
   task automatic t_lock();
      lock = 1'b1;
      u_host.wr(PWTR_LOW_HIGH_BYTE_ADDR, 8'h55);
      chk(wrf, 1'b1);
      u_host.rd(PWTR_LOW_HIGH_BYTE_ADDR, d);
      chk(d, 8'h00);
   endtask : t_lock

   // Main sequence after a reset of 12 cycles.
   initial
   begin
      rst_n = 1'b0;
      lock = 1'b0;
      fault = 1'b0;
      sv = 1'b0;
      sense = 1'b0;
      stretch = PWTR_STRETCH_NONE;
      p = 16'h0000;
      repeat (12) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      t_reset();
      t_regs();
      t_window();
      t_fault();
      t_disable();
      t_lock();
      finish_test();
   end

   // Watchdog well beyond the roughly 90 cycles the tests need.
   initial
   begin
      #100000;
      fail_count++;
      finish_test();
   end

endmodule : tb
